// >>> boundary_scan_tap_logic.sv
// Boundary-scan test port logic: controller, instruction and data registers.
// Assumes the test clock comes from the external controller; chip side on mclk.
// Notes on behaviour
// - Four-bit instruction register, sixteen codes
// - All shift registers shift LSB first
// - Code 0x0 puts pin chain in path
// - EXTEST drives output latches immediately
// - EXTEST capture samples, shift, update drives pins
// - Each pin: pull-up, enable, data, input cells
// - IDCODE 0x1 selected at power-up
// - ID bits 31:28 hold revision
// - ID bits 27:12 hold part code
// - ID bits 11:1 maker, bit0 one
// - IDCODE capture loads ID, shift outputs
// - Bypass single stage, zero after capture
// - Reset register one holds chip reset
// - Reset register output is unlatched
// - Reset time-out follows release of bit
// - Chip reset tri-states all port outputs except while EXTEST drives them from the latches
// - Port works only when fuse and enable
// - Works with chip clock stopped
// - Code 0xC selects reset register
// - Code 0xF selects bypass, captures zero
// - Code 0x2 sample/preload, pins untouched
`timescale 1ns/1ps
module boundary_scan_tap_logic (
    input  wire logic                                 mclk,
    input  wire logic                                 reset_n,
    input  wire logic                                 tck,
    input  wire logic                                 tms,
    input  wire logic                                 tdi,
    input  wire logic                                 tdo_unused_in,
    input  wire logic                                 test_port_enable_fuse,
    input  wire logic                                 test_port_disable_bit,
    input  wire logic                                 long_timeout_fuse,
    input  wire logic [scan_tap_pkg::PIN_COUNT-1:0]   core_pud,
    input  wire logic [scan_tap_pkg::PIN_COUNT-1:0]   core_oe,
    input  wire logic [scan_tap_pkg::PIN_COUNT-1:0]   core_out,
    input  wire logic [scan_tap_pkg::PIN_COUNT-1:0]   pin_in,
    output logic                                      tdo,
    output logic                                      tdo_oe,
    output logic [scan_tap_pkg::PIN_COUNT-1:0]        pin_pud,
    output logic [scan_tap_pkg::PIN_COUNT-1:0]        pin_oe,
    output logic [scan_tap_pkg::PIN_COUNT-1:0]        pin_out,
    output logic [scan_tap_pkg::PIN_COUNT-1:0]        pin_in_core,
    output logic                                      chip_reset
);

    localparam int PN = scan_tap_pkg::PIN_COUNT;
    localparam int CL = scan_tap_pkg::CHAIN_LEN;

    // Test clock domain state
    typedef struct packed {
        scan_tap_pkg::tap_state_t                  state;
        logic [scan_tap_pkg::IR_WIDTH-1:0]         ir_shift;
        logic [scan_tap_pkg::IR_WIDTH-1:0]         instruction_register;
        logic [scan_tap_pkg::ID_WIDTH-1:0]         id_shift;
        logic                                      bypass;
        logic                                      reset_bit;
        logic [CL-1:0]                             chain;
        logic [CL-1:0]                             latch;
        logic                                      tdo_q;
        logic                                      tdo_en;
    } tap_t;

    // Chip clock domain state
    typedef struct packed {
        logic [1:0]  en_sync;
        logic [1:0]  rst_sync;
        logic [PN-1:0] pin_s1;
        logic [PN-1:0] pin_s2;
        logic [15:0] timeout;
        logic        chip_reset;
        logic [PN-1:0] pud;
        logic [PN-1:0] oe;
        logic [PN-1:0] out;
    } core_t;

    tap_t  tap;
    tap_t  next_tap;
    core_t core;
    core_t next_core;

    function automatic scan_tap_pkg::tap_state_t tap_next(
        input scan_tap_pkg::tap_state_t s, input logic m);
        case (s)
            scan_tap_pkg::TEST_LOGIC_RESET: tap_next = m ? scan_tap_pkg::TEST_LOGIC_RESET
                                                         : scan_tap_pkg::RUN_IDLE;
            scan_tap_pkg::RUN_IDLE:   tap_next = m ? scan_tap_pkg::SELECT_DR
                                                   : scan_tap_pkg::RUN_IDLE;
            scan_tap_pkg::SELECT_DR:  tap_next = m ? scan_tap_pkg::SELECT_IR
                                                   : scan_tap_pkg::CAPTURE_DR;
            scan_tap_pkg::CAPTURE_DR: tap_next = m ? scan_tap_pkg::EXIT1_DR
                                                   : scan_tap_pkg::SHIFT_DR;
            scan_tap_pkg::SHIFT_DR:   tap_next = m ? scan_tap_pkg::EXIT1_DR
                                                   : scan_tap_pkg::SHIFT_DR;
            scan_tap_pkg::EXIT1_DR:   tap_next = m ? scan_tap_pkg::UPDATE_DR
                                                   : scan_tap_pkg::PAUSE_DR;
            scan_tap_pkg::PAUSE_DR:   tap_next = m ? scan_tap_pkg::EXIT2_DR
                                                   : scan_tap_pkg::PAUSE_DR;
            scan_tap_pkg::EXIT2_DR:   tap_next = m ? scan_tap_pkg::UPDATE_DR
                                                   : scan_tap_pkg::SHIFT_DR;
            scan_tap_pkg::UPDATE_DR:  tap_next = m ? scan_tap_pkg::SELECT_DR
                                                   : scan_tap_pkg::RUN_IDLE;
            scan_tap_pkg::SELECT_IR:  tap_next = m ? scan_tap_pkg::TEST_LOGIC_RESET
                                                   : scan_tap_pkg::CAPTURE_IR;
            scan_tap_pkg::CAPTURE_IR: tap_next = m ? scan_tap_pkg::EXIT1_IR
                                                   : scan_tap_pkg::SHIFT_IR;
            scan_tap_pkg::SHIFT_IR:   tap_next = m ? scan_tap_pkg::EXIT1_IR
                                                   : scan_tap_pkg::SHIFT_IR;
            scan_tap_pkg::EXIT1_IR:   tap_next = m ? scan_tap_pkg::UPDATE_IR
                                                   : scan_tap_pkg::PAUSE_IR;
            scan_tap_pkg::PAUSE_IR:   tap_next = m ? scan_tap_pkg::EXIT2_IR
                                                   : scan_tap_pkg::PAUSE_IR;
            scan_tap_pkg::EXIT2_IR:   tap_next = m ? scan_tap_pkg::UPDATE_IR
                                                   : scan_tap_pkg::SHIFT_IR;
            scan_tap_pkg::UPDATE_IR:  tap_next = m ? scan_tap_pkg::SELECT_DR
                                                   : scan_tap_pkg::RUN_IDLE;
            default:                  tap_next = scan_tap_pkg::TEST_LOGIC_RESET;
        endcase
    endfunction : tap_next

    // Port enable is taken straight from fuse and bit; while disabled the
    // controller is parked in reset so nothing leaks onto the pins.
    logic port_on;
    assign port_on = test_port_enable_fuse && !test_port_disable_bit;

    logic [scan_tap_pkg::ID_WIDTH-1:0] id_value;
    assign id_value = {scan_tap_pkg::ID_VERSION,
                       scan_tap_pkg::ID_PART,
                       scan_tap_pkg::ID_MAKER,
                       scan_tap_pkg::ID_MARK};

    // Chain capture: each pin group holds pull-up, enable, data and input
    logic [CL-1:0] chain_capture;
    always_comb
    begin
        chain_capture = '0;
        for (int p = 0; p < PN; p++)
        begin
            chain_capture[p*scan_tap_pkg::CELLS_PER_PIN + scan_tap_pkg::CELL_PUD] = core_pud[p];
            chain_capture[p*scan_tap_pkg::CELLS_PER_PIN + scan_tap_pkg::CELL_OE]  = core_oe[p];
            chain_capture[p*scan_tap_pkg::CELLS_PER_PIN + scan_tap_pkg::CELL_OUT] = core_out[p];
            chain_capture[p*scan_tap_pkg::CELLS_PER_PIN + scan_tap_pkg::CELL_IN]  = pin_in[p];
        end
    end

    always_comb
    begin
        logic [3:0] op;
        next_tap = tap;
        op = tap.instruction_register;
        next_tap.state = tap_next(tap.state, tms);
        case (tap.state)
            scan_tap_pkg::TEST_LOGIC_RESET:
            begin
                next_tap.instruction_register = scan_tap_pkg::OP_IDCODE;
            end
            scan_tap_pkg::CAPTURE_IR:
                next_tap.ir_shift = scan_tap_pkg::IR_CAPTURE;
            scan_tap_pkg::SHIFT_IR:
                next_tap.ir_shift = {tdi, tap.ir_shift[scan_tap_pkg::IR_WIDTH-1:1]};
            scan_tap_pkg::UPDATE_IR:
                next_tap.instruction_register = tap.ir_shift;
            scan_tap_pkg::CAPTURE_DR:
            begin
                case (op)
                    scan_tap_pkg::OP_IDCODE: next_tap.id_shift = id_value;
                    scan_tap_pkg::OP_EXTEST,
                    scan_tap_pkg::OP_SAMPLE: next_tap.chain = chain_capture;
                    scan_tap_pkg::OP_CHIP_RST: next_tap.reset_bit = tap.reset_bit;
                    default: next_tap.bypass = 1'b0;
                endcase
            end
            scan_tap_pkg::SHIFT_DR:
            begin
                case (op)
                    scan_tap_pkg::OP_IDCODE:
                        next_tap.id_shift = {tdi, tap.id_shift[scan_tap_pkg::ID_WIDTH-1:1]};
                    scan_tap_pkg::OP_EXTEST,
                    scan_tap_pkg::OP_SAMPLE:
                        next_tap.chain = {tdi, tap.chain[CL-1:1]};
                    scan_tap_pkg::OP_CHIP_RST:
                        next_tap.reset_bit = tdi;
                    default:
                        next_tap.bypass = tdi;
                endcase
            end
            scan_tap_pkg::UPDATE_DR:
            begin
                if (op == scan_tap_pkg::OP_EXTEST || op == scan_tap_pkg::OP_SAMPLE)
                    next_tap.latch = tap.chain;
            end
            default:
                next_tap.ir_shift = tap.ir_shift;
        endcase
        // Controller reset does not clear the reset register
        if (!port_on)
            next_tap.state = scan_tap_pkg::TEST_LOGIC_RESET;
        // Output stage; the standard changes it on the falling edge, but a
        // single-edge design keeps the domain simple at the cost of hold margin.
        // Enable and first bit appear on the edge that enters the shift state
        next_tap.tdo_en = port_on && (next_tap.state == scan_tap_pkg::SHIFT_DR
                                   || next_tap.state == scan_tap_pkg::SHIFT_IR);
        if (tap.state == scan_tap_pkg::CAPTURE_IR || tap.state == scan_tap_pkg::SHIFT_IR)
            next_tap.tdo_q = next_tap.ir_shift[0];
        else
            case (op)
                scan_tap_pkg::OP_IDCODE:   next_tap.tdo_q = next_tap.id_shift[0];
                scan_tap_pkg::OP_EXTEST,
                scan_tap_pkg::OP_SAMPLE:   next_tap.tdo_q = next_tap.chain[0];
                scan_tap_pkg::OP_CHIP_RST: next_tap.tdo_q = next_tap.reset_bit;
                default:                   next_tap.tdo_q = next_tap.bypass;
            endcase
    end

    // Test clock only; the chip clock may be stopped throughout
    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tap <= '0;
            tap.state <= scan_tap_pkg::TEST_LOGIC_RESET;
            tap.instruction_register <= scan_tap_pkg::OP_IDCODE;
        end
        else
            tap <= next_tap;
    end

    // Reset bit holds the chip without a latch; the time-out after release
    // needs the chip clock, as the real reset sequencer does.
    logic reset_hold;
    assign reset_hold = next_tap.reset_bit;

    logic extest_active;
    assign extest_active = tap.instruction_register == scan_tap_pkg::OP_EXTEST
                        && port_on;

    always_comb
    begin
        next_core = core;
        next_core.en_sync  = {core.en_sync[0], extest_active};
        next_core.rst_sync = {core.rst_sync[0], tap.reset_bit};
        next_core.pin_s1   = pin_in;
        next_core.pin_s2   = core.pin_s1;
        if (core.rst_sync[1])
            next_core.timeout = long_timeout_fuse ? scan_tap_pkg::TIMEOUT_LONG
                                                  : scan_tap_pkg::TIMEOUT_SHORT;
        else if (core.timeout != '0)
            next_core.timeout = core.timeout - 16'h0001;
        next_core.chip_reset = core.rst_sync[1] || core.timeout > 16'h0001;
        for (int p = 0; p < PN; p++)
        begin
            next_core.pud[p] = core_pud[p];
            next_core.oe[p]  = core_oe[p];
            next_core.out[p] = core_out[p];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            core <= '0;
        else
            core <= next_core;
    end

    // Pin stage on the test clock so EXTEST drives with the chip clock stopped
    typedef struct packed {
        logic [PN-1:0] pud;
        logic [PN-1:0] oe;
        logic [PN-1:0] out;
        logic [1:0]    rst;
    } pin_t;
    pin_t pins;
    pin_t next_pins;

    always_comb
    begin
        // Chip reset comes from the chip clock domain: two flops before use
        next_pins.rst = {pins.rst[0], core.chip_reset};
        for (int p = 0; p < PN; p++)
        begin
            if (next_tap.instruction_register == scan_tap_pkg::OP_EXTEST && port_on)
            begin
                next_pins.pud[p] = next_tap.latch[p*scan_tap_pkg::CELLS_PER_PIN
                                                  + scan_tap_pkg::CELL_PUD];
                next_pins.oe[p]  = next_tap.latch[p*scan_tap_pkg::CELLS_PER_PIN
                                                  + scan_tap_pkg::CELL_OE];
                next_pins.out[p] = next_tap.latch[p*scan_tap_pkg::CELLS_PER_PIN
                                                  + scan_tap_pkg::CELL_OUT];
            end
            else if (reset_hold || pins.rst[1])
            begin
                next_pins.pud[p] = 1'b0;
                next_pins.oe[p]  = 1'b0;
                next_pins.out[p] = 1'b0;
            end
            else
            begin
                next_pins.pud[p] = core.pud[p];
                next_pins.oe[p]  = core.oe[p];
                next_pins.out[p] = core.out[p];
            end
        end
    end

    always_ff @(posedge tck or negedge reset_n)
    begin
        if (!reset_n)
            pins <= '0;
        else
            pins <= next_pins;
    end

    assign tdo         = tap.tdo_q;
    assign tdo_oe      = tap.tdo_en;
    assign pin_pud     = pins.pud;
    assign pin_oe      = pins.oe;
    assign pin_out     = pins.out;
    assign pin_in_core = core.pin_s2;
    assign chip_reset  = core.chip_reset;

endmodule : boundary_scan_tap_logic

// >>> boundary_scan_tap_logic_test.sv
// Self-checking bench for the boundary-scan test port logic.
// Assumes the controller model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module boundary_scan_tap_logic_test;
    logic       mclk, mclk_run, reset_n, tck, tms, tdi, tdo, tdo_oe, chip_reset, fuse, port_off;
    logic [7:0] core_pud, core_oe, core_out, pin_in, pin_pud, pin_oe, pin_out, pin_in_core;
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cycles = 0;

    boundary_scan_tap_logic boundary_scan_tap_logic_inst (
        .mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo_unused_in(1'b0),
        .test_port_enable_fuse(fuse), .test_port_disable_bit(port_off), .long_timeout_fuse(1'b0),
        .core_pud(core_pud), .core_oe(core_oe), .core_out(core_out), .pin_in(pin_in), .tdo(tdo),
        .tdo_oe(tdo_oe), .pin_pud(pin_pud), .pin_oe(pin_oe), .pin_out(pin_out),
        .pin_in_core(pin_in_core), .chip_reset(chip_reset)
    );
    scan_controller_model ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    // Gated so the chip clock can be stopped while the test port keeps working
    always #12.5 mclk = mclk_run ? ~mclk : 1'b0;

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [31:0] pack(input logic [7:0] u, input logic [7:0] e,
                                         input logic [7:0] o);
        pack = '0;
        for (int p = 0; p < 8; p++)
            pack[4*p +: 3] = {o[p], e[p], u[p]};
    endfunction : pack

    function automatic logic [7:0] ins(input logic [31:0] d);
        for (int p = 0; p < 8; p++)
            ins[p] = d[4*p+3];
    endfunction : ins

    task automatic ir(input logic [3:0] code);
        logic [31:0] d;
        ctl.scan(1'b1, 4, {28'h0, code}, d);
        chk(d, 32'(scan_tap_pkg::IR_CAPTURE));
    endtask : ir

    task automatic id_scan();
        logic [31:0] d;
        ctl.scan(1'b0, 32, 32'h0, d);
        chk(32'(d[31:28]), 32'(scan_tap_pkg::ID_VERSION));
        chk(32'(d[27:12]), 32'(scan_tap_pkg::ID_PART));
        chk({20'h0, d[11:0]}, {20'h0, scan_tap_pkg::ID_MAKER, 1'b1});
    endtask : id_scan

    task automatic pins(input logic [7:0] u, input logic [7:0] e, input logic [7:0] o);
        chk(32'(pin_pud), 32'(u));
        chk(32'(pin_oe), 32'(e));
        chk(32'(pin_out), 32'(o));
    endtask : pins

    task automatic set_pins(input logic [7:0] v);
        @(posedge mclk);
        pin_in <= v;
        repeat (3) @(posedge mclk);
    endtask : set_pins

    task automatic t_idcode();
        logic q;
        ctl.pulse(1'b0, 1'b0, q);
        id_scan();
        $display("idcode after reset done");
    endtask : t_idcode

    task automatic t_bypass();
        logic [31:0] d;
        for (int k = 0; k < 2; k++)
        begin
            ir(k == 0 ? scan_tap_pkg::OP_BYPASS : 4'h7);
            ctl.scan(1'b0, 9, 32'h0AD, d);
            chk(d, 32'h15A);
        end
        $display("bypass done");
    endtask : t_bypass

    task automatic t_extest();
        logic [31:0] d;
        @(posedge mclk);
        core_pud <= 8'h0F;
        core_oe <= 8'h33;
        core_out <= 8'h55;
        set_pins(8'hA5);
        ir(scan_tap_pkg::OP_SAMPLE);
        ctl.scan(1'b0, 32, pack(8'h3C, 8'hC3, 8'h96), d);
        chk(32'(ins(d)), 32'hA5);
        pins(8'h0F, 8'h33, 8'h55);
        ir(scan_tap_pkg::OP_EXTEST);
        pins(8'h3C, 8'hC3, 8'h96);
        set_pins(8'h5A);
        ctl.scan(1'b0, 32, pack(8'hA0, 8'h0F, 8'h5A), d);
        chk(32'(ins(d)), 32'h5A);
        pins(8'hA0, 8'h0F, 8'h5A);
        $display("sample and extest done");
    endtask : t_extest

    task automatic t_chip_reset();
        logic [31:0] d;
        int          n;
        int          ts = int'(scan_tap_pkg::TIMEOUT_SHORT);
        ir(scan_tap_pkg::OP_CHIP_RST);
        ctl.scan(1'b0, 1, 32'h1, d);
        n = 0;
        while (chip_reset !== 1'b1 && n < 8)
        begin
            @(negedge mclk);
            n++;
        end
        chk(32'(chip_reset), 32'h1);
        pins(8'h00, 8'h00, 8'h00);
        ctl.scan(1'b0, 1, 32'h0, d);
        chk(d, 32'h1);
        n = 0;
        while (chip_reset === 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk(32'(n >= ts - 2 && n <= ts + 8), 32'h1);
        $display("chip reset done");
    endtask : t_chip_reset

    task automatic t_port_off();
        logic [31:0] d;
        logic        q;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge mclk);
            fuse <= (k == 1);
            port_off <= (k == 1);
            repeat (3) @(posedge mclk);
            ctl.scan(1'b1, 4, {28'h0, scan_tap_pkg::OP_BYPASS}, d);
            chk(32'(tdo_oe), 32'h0);
            @(posedge mclk);
            fuse <= 1'b1;
            port_off <= 1'b0;
            repeat (3) @(posedge mclk);
            mclk_run = (k == 0);
            ctl.pulse(1'b0, 1'b0, q);
            id_scan();
            mclk_run = 1'b1;
        end
        $display("port disable done");
    endtask : t_port_off

    initial
    begin
        mclk = 1'b0;
        mclk_run = 1'b1;
        reset_n = 1'b0;
        fuse = 1'b1;
        port_off = 1'b0;
        core_pud = 8'h00;
        core_oe = 8'h00;
        core_out = 8'h00;
        pin_in = 8'h00;
        ctl.tap_reset();
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        t_idcode();
        t_bypass();
        t_extest();
        t_chip_reset();
        t_port_off();
        conclude();
    end
endmodule : boundary_scan_tap_logic_test

// >>> scan_controller_model.sv
// Behavioural external test controller driving the four-wire test port.
// Assumes one task call at a time; the test clock idles low between frames.
`timescale 1ns/1ps
module scan_controller_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // 12 ns test clock; tdo is read just before the rise that moves it on
    task automatic pulse(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #6;
        q = tdo;
        tck = 1'b1;
        #6;
        tck = 1'b0;
    endtask : pulse

    task automatic tap_reset();
        logic q;
        repeat (5) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask : tap_reset

    // Idle to idle; tdi toggles outside the shift so no stale level is seen
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, ~tdi, q);
        if (ir)
            pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++)
        begin
            pulse(i == n - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask : scan
endmodule : scan_controller_model

// >>> scan_tap_asserts.sv
// Checker for the boundary-scan test port logic, bound to the top module.
// Assumes only the top module's ports; test clock and chip clock are separate domains.
`timescale 1ns/1ps
module scan_tap_asserts (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       tck,
    input wire logic       tms,
    input wire logic       tdo_oe,
    input wire logic       chip_reset,
    input wire logic       test_port_enable_fuse,
    input wire logic       test_port_disable_bit,
    input wire logic       long_timeout_fuse,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_in_core
);
    logic [15:0] hi_cnt;
    logic [1:0]  up_cnt;

    // Length of the current chip reset, saturating so a long hold cannot wrap
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hi_cnt <= '0;
            up_cnt <= '0;
        end
        else
        begin
            hi_cnt <= !chip_reset ? '0 : (&hi_cnt ? hi_cnt : hi_cnt + 16'h0001);
            up_cnt <= (up_cnt == 2'h3) ? up_cnt : up_cnt + 2'h1;
        end
    end

    oe_enter_a: assert property (@(posedge tck) disable iff (!reset_n)
        $rose(tdo_oe) |-> !$past(tms) && !$past(tms, 2)) else $error("shift entered without 0,0");
    oe_exit_a: assert property (@(posedge tck) disable iff (!reset_n)
        $fell(tdo_oe) |-> $past(tms)) else $error("shift left without mode high");
    shift_hold_a: assert property (@(posedge tck) disable iff (!reset_n)
        tdo_oe && !tms |=> tdo_oe) else $error("shift left with mode low");
    port_off_a: assert property (@(posedge tck) disable iff (!reset_n)
        !test_port_enable_fuse || test_port_disable_bit |=> !tdo_oe) else $error("port shifts while off");
    tristate_oe_a: assert property (@(posedge mclk) disable iff (!reset_n)
        chip_reset && $past(chip_reset) |-> pin_oe == '0) else $error("pin driven in reset");
    tristate_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
        chip_reset && $past(chip_reset) |-> pin_out == '0) else $error("pin data in reset");
    reset_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $fell(chip_reset) |-> hi_cnt >= (long_timeout_fuse ? scan_tap_pkg::TIMEOUT_LONG
        : scan_tap_pkg::TIMEOUT_SHORT)) else $error("chip reset released too early");
    input_sync_a: assert property (@(posedge mclk) disable iff (!reset_n)
        up_cnt == 2'h3 |-> pin_in_core == $past(pin_in, 2)) else $error("pin input path broken");
endmodule : scan_tap_asserts

bind boundary_scan_tap_logic scan_tap_asserts scan_tap_asserts_inst (
    .mclk(mclk), .reset_n(reset_n), .tck(tck), .tms(tms), .tdo_oe(tdo_oe),
    .chip_reset(chip_reset), .test_port_enable_fuse(test_port_enable_fuse),
    .test_port_disable_bit(test_port_disable_bit), .long_timeout_fuse(long_timeout_fuse),
    .pin_oe(pin_oe), .pin_out(pin_out), .pin_in(pin_in), .pin_in_core(pin_in_core)
);

// >>> scan_tap_pkg.sv
// Constants and types for the boundary-scan test port logic.
// Assumes a single design module that imports nothing and names everything by package.
package scan_tap_pkg;

    localparam int IR_WIDTH      = 4;
    localparam int ID_WIDTH      = 32;
    localparam int PIN_COUNT     = 8;
    localparam int CELLS_PER_PIN = 4;
    localparam int CHAIN_LEN     = PIN_COUNT * CELLS_PER_PIN;

    localparam logic [3:0] OP_EXTEST   = 4'h0;
    localparam logic [3:0] OP_IDCODE   = 4'h1;
    localparam logic [3:0] OP_SAMPLE   = 4'h2;
    localparam logic [3:0] OP_CHIP_RST = 4'hC;
    localparam logic [3:0] OP_BYPASS   = 4'hF;

    // Captured into the instruction register, low two bits fixed by the standard
    localparam logic [3:0] IR_CAPTURE  = 4'h1;

    // Identification fields; part and maker values are arbitrary
    localparam logic [3:0]  ID_VERSION  = 4'h0;
    localparam logic [15:0] ID_PART     = 16'h1234;
    localparam logic [10:0] ID_MAKER    = 11'h2A5;
    localparam logic        ID_MARK     = 1'b1;

    // Cell order inside one pin group
    localparam int CELL_PUD = 0;
    localparam int CELL_OE  = 1;
    localparam int CELL_OUT = 2;
    localparam int CELL_IN  = 3;

    // Reset time-out in chip clocks per fuse option
    localparam logic [15:0] TIMEOUT_SHORT = 16'h0010;
    localparam logic [15:0] TIMEOUT_LONG  = 16'h1000;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPDATE_IR
    } tap_state_t;

endpackage : scan_tap_pkg
